// ==== system_integration_control_status.sv ====
`timescale 1ns/10ps
// Overview of operation
// R1: control bit 5 low gates debug clock with test port; high keeps it running
// R2: writing 1 to control bit 4 resets the device; bit reads zero
// R3: stop field 00 lets stop instruction enter stop mode, 01 ignores it
// R4: stop field 10 and 11 act like 00 and 01 and lock the field
// R5: wait field 00 lets wait instruction enter wait mode, 01 ignores it
// R6: wait field 10 and 11 act like 00 and 01 and lock the field
// R7: software writes zero to control bits 15 to 6
// R8: reset status is read-only and records cause of latest reset
// R9: status cleared asynchronously by power-on, then updated synchronously by precedence
// R10: with resets in sequence, only the latest source is shown
// R11: simultaneous sources flag only the highest: power-on, pin, refloss, timeout, soft
// R12: power-on sets its flag; pin held after power-on swaps it for pin flag
// R13: status bit 6 marks a reset caused by the software trigger
// R14: status bit 5 marks watchdog timeout; it selects the watchdog vector
// R15: bit 4 refloss, bit 3 pin, bit 2 power-on; bits 1 to 0 zero
// R16: refloss flag set at code start selects the watchdog vector
// R17: writes to unassigned addresses do nothing; reads return undefined data
// R18: writes to the reset status register are ignored
// R19: a locked field keeps its value on writes until the next reset
module system_integration_control_status
	import sysint_pkg::*;
(
	// clock and resets
	input wire logic mclk,
	input wire logic reset,
	input wire logic power_on_reset,
	input wire logic pin_reset_raw,
	input wire logic watchdog_refloss_reset,
	input wire logic watchdog_timeout_reset,
	// register port
	input wire logic [5:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// core and system
	input wire logic debug_port_enabled,
	input wire logic stop_request,
	input wire logic wait_request,
	output logic debug_clock_enable,
	output logic stop_enter,
	output logic wait_enter,
	output logic soft_reset_request,
	output logic use_watchdog_vector,
	// plain configuration out
	output logic [15:0] clock_output_select,
	output logic [15:0] peripheral_clock_rate
);
	logic [15:0] system_control;
	logic [15:0] reset_cause;
	logic [15:0] plain_regs [plain_count];
	logic stop_locked;
	logic wait_locked;
	logic pin_s1, pin_s2, pin_s3;
	logic pin_level;
	logic soft_pending;
	logic [15:0] next_cause;

	function automatic logic hits(input logic [5:0] a, input logic [5:0] target);
		return a == target;
	endfunction : hits

	// pin reset is asynchronous; three stages, change accepted when two agree
	always_ff @(posedge mclk or posedge power_on_reset) begin
		if (power_on_reset) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
			pin_level <= 1'b0;
		end else begin
			pin_s1 <= pin_reset_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (pin_s2 == pin_s3) begin
				pin_level <= pin_s3;
			end
		end
	end

	// soft trigger remembered until the system reset arrives
	always_ff @(posedge mclk or posedge power_on_reset) begin
		if (power_on_reset) begin
			soft_pending <= 1'b0;
		end else if (reset) begin
			soft_pending <= 1'b0;
		end else if (wr && hits(addr, system_control_addr) && wdata[soft_reset_trigger_bit]) begin
			soft_pending <= 1'b1; // [R2]
		end
	end
	assign soft_reset_request = soft_pending; // [R2]

	// cause encoding by precedence; higher sources win when together
	always_comb begin
		next_cause = 16'h0000; // [R15]
		if (pin_level) begin
			next_cause[pin_reset_flag_bit] = 1'b1; // [R12] [R11]
		end else if (watchdog_refloss_reset) begin
			next_cause[watchdog_refloss_flag_bit] = 1'b1; // [R11]
		end else if (watchdog_timeout_reset) begin
			next_cause[watchdog_timeout_flag_bit] = 1'b1; // [R11]
		end else if (soft_pending) begin
			next_cause[soft_reset_flag_bit] = 1'b1; // [R13]
		end else begin
			next_cause = reset_cause;
		end
	end

	// status: async clear to power-on value, then only system resets touch it
	always_ff @(posedge mclk or posedge power_on_reset) begin
		if (power_on_reset) begin
			reset_cause <= reset_cause_reset; // [R9] [R12]
		end else if (reset) begin
			reset_cause <= next_cause; // [R8] [R10] [R9]
		end
		// bus writes never reach this register [R18]
	end

	// control register; locks survive until any reset
	always_ff @(posedge mclk or posedge power_on_reset) begin
		if (power_on_reset) begin
			system_control <= system_control_reset;
			stop_locked <= 1'b0;
			wait_locked <= 1'b0;
		end else if (reset) begin
			system_control <= system_control_reset;
			stop_locked <= 1'b0;
			wait_locked <= 1'b0;
		end else if (wr && hits(addr, system_control_addr)) begin
			// upper bits kept zero whatever software writes [R7]
			system_control[debug_clock_always_on_bit] <= wdata[debug_clock_always_on_bit];
			if (!stop_locked) begin
				system_control[stop_field_lo +: 2] <= wdata[stop_field_lo +: 2]; // [R19]
				stop_locked <= wdata[stop_field_lo + lock_bit]; // [R4]
			end
			if (!wait_locked) begin
				system_control[wait_field_lo +: 2] <= wdata[wait_field_lo +: 2]; // [R19]
				wait_locked <= wdata[wait_field_lo + lock_bit]; // [R6]
			end
		end
	end

	// instruction gating; the lock bit does not change the meaning
	assign stop_enter = stop_request
		&& !system_control[stop_field_lo + disable_bit]; // [R3] [R4]
	assign wait_enter = wait_request
		&& !system_control[wait_field_lo + disable_bit]; // [R5] [R6]
	assign debug_clock_enable = system_control[debug_clock_always_on_bit]
		|| debug_port_enabled; // [R1]
	assign use_watchdog_vector = reset_cause[watchdog_timeout_flag_bit]
		|| reset_cause[watchdog_refloss_flag_bit]; // [R14] [R16]

	// plain storage registers, reset by any reset
	generate
		for (genvar i = 0; i < plain_count; i++) begin : g_plain
			always_ff @(posedge mclk or posedge power_on_reset) begin
				if (power_on_reset) begin
					plain_regs[i] <= (i == 0) ? clock_output_select_reset : plain_reset;
				end else if (reset) begin
					plain_regs[i] <= (i == 0) ? clock_output_select_reset : plain_reset;
				end else if (wr && hits(addr, 6'(plain_first + i))) begin
					plain_regs[i] <= wdata;
				end
			end
		end
	endgenerate
	assign clock_output_select = plain_regs[0];
	assign peripheral_clock_rate = plain_regs[1];

	// read data one cycle after strobe; unmapped reads give zero
	always_ff @(posedge mclk or posedge power_on_reset) begin
		if (power_on_reset) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			if (hits(addr, system_control_addr)) begin
				rdata <= system_control & 16'h002f; // trigger reads zero [R2]
			end else if (hits(addr, reset_cause_addr)) begin
				rdata <= reset_cause; // [R8]
			end else if (addr >= 6'(plain_first) && addr < 6'(plain_first + plain_count)) begin
				rdata <= plain_regs[5'(addr - 6'(plain_first))];
			end else begin
				rdata <= 16'h0000; // [R17]
			end
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule : system_integration_control_status

// ==== sysint_pkg.sv ====
package sysint_pkg;
	// register indices on the plain port (word addresses)
	localparam logic [5:0] system_control_addr = 6'h00;
	localparam logic [5:0] reset_cause_addr = 6'h01;
	localparam logic [5:0] clock_output_select_addr = 6'h0a;
	localparam logic [5:0] peripheral_clock_rate_addr = 6'h0b;
	localparam logic [5:0] peripheral_clock_enable_low_addr = 6'h0c;
	localparam logic [5:0] peripheral_clock_enable_high_addr = 6'h0d;
	localparam logic [5:0] stop_keepalive_low_addr = 6'h0e;
	localparam logic [5:0] stop_keepalive_high_addr = 6'h0f;
	localparam logic [5:0] short_address_base_high_addr = 6'h10;
	localparam logic [5:0] short_address_base_low_addr = 6'h11;
	localparam logic [5:0] peripheral_protection_addr = 6'h12;
	localparam logic [5:0] port_a_pin_select_low_addr = 6'h13;
	localparam logic [5:0] port_a_pin_select_high_addr = 6'h14;
	localparam logic [5:0] port_b_pin_select_low_addr = 6'h15;
	localparam logic [5:0] port_b_pin_select_high_addr = 6'h16;
	localparam logic [5:0] port_cd_pin_select_addr = 6'h17;
	localparam logic [5:0] modulator_source_select_addr = 6'h18;
	localparam logic [5:0] converter_source_select_addr = 6'h19;
	localparam logic [5:0] timer_source_select_addr = 6'h1a;
	localparam int plain_first = 10;
	localparam int plain_count = 17;
	// control field positions
	localparam int debug_clock_always_on_bit = 5;
	localparam int soft_reset_trigger_bit = 4;
	localparam int stop_field_lo = 2;
	localparam int wait_field_lo = 0;
	localparam int lock_bit = 1;
	localparam int disable_bit = 0;
	// status field positions
	localparam int soft_reset_flag_bit = 6;
	localparam int watchdog_timeout_flag_bit = 5;
	localparam int watchdog_refloss_flag_bit = 4;
	localparam int pin_reset_flag_bit = 3;
	localparam int power_on_flag_bit = 2;
	// values after reset
	localparam logic [15:0] system_control_reset = 16'h0000;
	localparam logic [15:0] reset_cause_reset = 16'h0004;
	localparam logic [15:0] plain_reset = 16'h0000;
	localparam logic [15:0] clock_output_select_reset = 16'h0020;
endpackage : sysint_pkg

// ==== sics_assertions.sv ====
`timescale 1ns/10ps
// port-level checks on the register port and the core-facing gates
module sics_checker (
	// clock and resets
	input wire logic mclk, reset, power_on_reset,
	// register port
	input wire logic [5:0] addr,
	input wire logic [15:0] wdata, rdata,
	input wire logic wr, rd,
	// core side
	input wire logic debug_port_enabled, stop_request, wait_request,
	input wire logic debug_clock_enable, stop_enter, wait_enter, soft_reset_request
);
	// either reset kind voids every check in flight
	default clocking @(posedge mclk); endclocking
	default disable iff (reset || power_on_reset);
	dbg_clock_on_a: assert property (
		debug_port_enabled |-> debug_clock_enable) else $error("debug clock gated");
	trig_reads_zero_a: assert property (
		rd && addr == 6'h00 |=> rdata[15:4] == 12'h000) else $error("control upper bits set");
	soft_request_a: assert property (
		wr && addr == 6'h00 && wdata[4] |=> soft_reset_request) else $error("no soft request");
	request_holds_a: assert property (
		soft_reset_request |=> soft_reset_request) else $error("soft request dropped");
	stop_gate_a: assert property (
		stop_enter |-> stop_request) else $error("stop without request");
	wait_gate_a: assert property (
		wait_enter |-> wait_request) else $error("wait without request");
	status_zero_a: assert property (
		rd && addr == 6'h01 |=> rdata[1:0] == 2'h0 && rdata[15:7] == 9'h000) else $error("status reserved");
	status_single_a: assert property (
		rd && addr == 6'h01 |=> $onehot(rdata[6:2])) else $error("status not single");
endmodule : sics_checker

bind system_integration_control_status sics_checker u_sics_checker (.mclk(mclk), .reset(reset),
	.power_on_reset(power_on_reset), .addr(addr), .wdata(wdata), .rdata(rdata), .wr(wr), .rd(rd),
	.debug_port_enabled(debug_port_enabled), .stop_request(stop_request),
	.wait_request(wait_request), .debug_clock_enable(debug_clock_enable),
	.stop_enter(stop_enter), .wait_enter(wait_enter), .soft_reset_request(soft_reset_request));

// ==== core_bus.sv ====
`timescale 1ns/10ps
// core side of the register port: one-cycle strobes launched just after an edge
module core_bus (
	// clock
	input wire logic mclk,
	// register port
	input wire logic [15:0] rdata,
	output logic [5:0] addr,
	output logic [15:0] wdata,
	output logic wr,
	output logic rd
);
	initial {addr, wdata, wr, rd} = '0;
	// write strobe for one cycle; reserved control bits always go out as zero
	task put(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= (a == 6'h00) ? (d & 16'h003f) : d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		wdata <= ~d; // stale data must not look valid
	endtask : put
	// read data stands only in the cycle after the strobe
	task get(input logic [5:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : get
endmodule : core_bus

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
	logic mclk = 1'b0, reset = 1'b1, power_on_reset = 1'b1, pin_reset_raw = 1'b0;
	logic watchdog_refloss_reset = 1'b0, watchdog_timeout_reset = 1'b0;
	logic debug_port_enabled = 1'b0, stop_request = 1'b0, wait_request = 1'b0;
	logic [5:0] addr;
	logic [15:0] wdata, rdata, got;
	logic wr, rd, debug_clock_enable, stop_enter, wait_enter, soft_reset_request;
	logic use_watchdog_vector;
	logic [15:0] clock_output_select, peripheral_clock_rate;
	int fail_count = 0;
	int checks_done = 0;
	// 250 MHz system clock
	always #2 mclk = ~mclk;
	system_integration_control_status u_system_integration_control_status (.mclk, .reset,
		.power_on_reset, .pin_reset_raw, .watchdog_refloss_reset, .watchdog_timeout_reset,
		.addr, .wdata, .wr, .rd, .rdata, .debug_port_enabled, .stop_request, .wait_request,
		.debug_clock_enable, .stop_enter, .wait_enter, .soft_reset_request,
		.use_watchdog_vector, .clock_output_select, .peripheral_clock_rate);
	core_bus u_core_bus (.mclk, .rdata, .addr, .wdata, .wr, .rd);
	task check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// 24-cycle system reset with chosen sources held, then cause read back
	task rst_cause(input logic po, pin, lor, tor, input logic [15:0] want);
		@(posedge mclk);
		{reset, power_on_reset, pin_reset_raw} <= {1'b1, po, pin};
		{watchdog_refloss_reset, watchdog_timeout_reset} <= {lor, tor};
		repeat (16) @(posedge mclk);
		// power-on drops first so a held pin can still be seen during system reset
		power_on_reset <= 1'b0;
		repeat (8) @(posedge mclk);
		{reset, power_on_reset, pin_reset_raw, watchdog_refloss_reset} <= 4'h0;
		watchdog_timeout_reset <= 1'b0;
		u_core_bus.get(6'h01, got);
		check(got, want);
	endtask : rst_cause
	// mode fields, locks, debug clock, ignored writes
	task t_control;
		{stop_request, wait_request} <= 2'b11;
		u_core_bus.put(6'h01, 16'hffff);
		u_core_bus.put(6'h05, 16'hffff);
		u_core_bus.get(6'h00, got);
		check(got, 16'h0000);
		u_core_bus.get(6'h01, got);
		check(got, 16'h0004);
		u_core_bus.put(6'h00, 16'h0005);
		@(negedge mclk) check({stop_enter, wait_enter}, 16'h0000);
		u_core_bus.put(6'h00, 16'h002e);
		@(negedge mclk) check({debug_clock_enable, stop_enter, wait_enter}, 16'h0005);
		u_core_bus.put(6'h00, 16'h0001);
		u_core_bus.get(6'h00, got);
		check(got, 16'h000e);
		check(debug_clock_enable, 16'h0000);
		$display("control test done");
	endtask : t_control
	// reset causes by precedence and sequence
	task t_causes;
		rst_cause(1'b0, 1'b0, 1'b1, 1'b1, 16'h0010);
		check(use_watchdog_vector, 16'h0001);
		u_core_bus.get(6'h00, got);
		check(got, 16'h0000);
		rst_cause(1'b0, 1'b0, 1'b0, 1'b1, 16'h0020);
		check(use_watchdog_vector, 16'h0001);
		rst_cause(1'b0, 1'b1, 1'b1, 1'b1, 16'h0008);
		u_core_bus.put(6'h00, 16'h0010);
		@(negedge mclk) check(soft_reset_request, 16'h0001);
		rst_cause(1'b0, 1'b0, 1'b0, 1'b0, 16'h0040);
		rst_cause(1'b1, 1'b1, 1'b0, 1'b0, 16'h0008);
		$display("cause test done");
	endtask : t_causes
	// plain storage registers and an unmapped read
	task t_plain;
		check(clock_output_select, 16'h0020);
		u_core_bus.get(6'h0a, got);
		check(got, 16'h0020);
		u_core_bus.put(6'h0b, 16'h1234);
		@(negedge mclk) check(peripheral_clock_rate, 16'h1234);
		u_core_bus.get(6'h0b, got);
		check(got, 16'h1234);
		u_core_bus.get(6'h1b, got);
		check(got, 16'h0000);
		$display("plain test done");
	endtask : t_plain
	// main sequence
	initial begin
		rst_cause(1'b1, 1'b0, 1'b0, 1'b0, 16'h0004);
		t_plain();
		t_control();
		t_causes();
		conclude();
	end
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#20000;
		fail_count++;
		conclude();
	end
endmodule : testbench
